// [logic/ddr3_mode_reg_two_three_decode.sv]
// second and third mode register decode with termination and readout control
// assumes command pins already synchronised to mclk by the command front end
//
// Contract
// R1 - controller zeroes reserved second register bits
// R2 - write termination applies even with nominal off
// R3 - write leveling uses nominal termination only
// R4 - self refresh may drop banks outside range
// R5 - write column latency from address bits 3-5
// R6 - only whole clock write latencies exist
// R7 - total write delay equals additive plus column
// R8 - address bits 9-10 select dynamic write termination
// R9 - bit 7 doubles self refresh rate always
// R10 - controller sets hot bit above 85C
// R11 - controller doubles refresh rate when hot
// R12 - third register load decode on bank 3
// R13 - controller zeroes reserved third register bits
// R14 - readout location ignored when readout off
// R15 - readout mode returns fixed pattern on reads
// R16 - second register load decode on bank 2
// R17 - latency codes 0-5 give 5-10 clocks
// R18 - dynamic termination code decode, 11 reserved
// R19 - load updates only addressed register fields
`default_nettype none
`include "mode_two_three_params.svh"

module ddr3_mode_reg_two_three_decode
(
    // clock and reset
    input  wire logic                        mclk,
    input  wire logic                        rst_b,
    // command and address
    input  wire logic                        cs_b,
    input  wire logic                        ras_b,
    input  wire logic                        cas_b,
    input  wire logic                        we_b,
    input  wire logic [2:0]                  bank_addr,
    input  wire logic [13:0]                 addr,
    // operating context
    input  wire logic [3:0]                  additive_latency,
    input  wire logic                        write_leveling,
    input  wire logic                        write_burst,
    input  wire logic [2:0]                  nominal_term,
    input  wire logic                        read_burst,
    input  wire logic [7:0]                  array_data,
    // decoded outputs
    output var  logic [2:0]                  partial_array_retention,
    output var  logic [3:0]                  write_column_latency,
    output var  logic                        wcl_reserved,
    output var  logic [4:0]                  total_write_delay,
    output var  logic [1:0]                  dyn_term_code,
    output var  logic                        dyn_term_reserved,
    output var  logic                        hot_self_refresh_option,
    output var  logic                        self_refresh_2x,
    output var  logic                        multipurpose_readout,
    output var  logic [1:0]                  readout_location,
    output var  logic [7:0]                  bank_keep_mask,
    output var  mode_two_three_pkg::term_sel_t term_sel,
    output var  logic [2:0]                  term_value,
    output var  logic [7:0]                  read_data
);
    import mode_two_three_pkg::*;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    function automatic logic is_mrs(input logic [2:0] ba,
                                    input logic [2:0] want);
        is_mrs = !cs_b && !ras_b && !cas_b && !we_b && (ba == want);
    endfunction

    wire logic load_two   = is_mrs(bank_addr, `BA_MODE_TWO); // [R16]
    wire logic load_three = is_mrs(bank_addr, `BA_MODE_THREE); // [R12]

    // ------------------------------------------------------------
    // mode register storage
    // ------------------------------------------------------------
    logic [2:0] ret_reg;
    logic [2:0] wcl_reg;
    logic       hot_reg;
    logic [1:0] dwt_reg;
    logic       rdo_reg;
    logic [1:0] loc_reg;

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            ret_reg <= `RET_FULL;
            wcl_reg <= `WCL_RST;
            hot_reg <= 1'b0;
            dwt_reg <= `DWT_OFF;
            rdo_reg <= 1'b0;
            loc_reg <= 2'h0;
        end
        else if (load_two) // [R19]
        begin
            ret_reg <= addr[`RET_MSB:`RET_LSB];
            wcl_reg <= addr[`WCL_MSB:`WCL_LSB]; // [R5]
            hot_reg <= addr[`HOT_BIT]; // [R9]
            dwt_reg <= addr[`DWT_MSB:`DWT_LSB]; // [R8]
        end
        else if (load_three) // [R19]
        begin
            rdo_reg <= addr[`RDO_EN_BIT];
            loc_reg <= addr[`RDO_LOC_MSB:`RDO_LOC_LSB];
        end
    end

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    // whole clock latencies only, reserved codes flagged
    wire logic wcl_res_w = wcl_reg > `WCL_MAX_CODE; // [R17]
    wire logic [3:0] wcl_w = `WCL_BASE + {1'b0, wcl_reg}; // [R6] [R17]
    wire logic [4:0] twd_w = {1'b0, additive_latency}
                           + {1'b0, wcl_w}; // [R7]
    wire logic dwt_on_w  = (dwt_reg == `DWT_RZQ4)
                         || (dwt_reg == `DWT_RZQ2); // [R18]

    // banks kept through self refresh, others may be lost
    logic [7:0] keep_w;
    always_comb
    begin
        keep_w = 8'hFF;
        case (ret_reg) // [R4]
            3'h1:    keep_w = 8'h0F;
            3'h2:    keep_w = 8'h03;
            3'h3:    keep_w = 8'h01;
            3'h4:    keep_w = 8'hFC;
            3'h5:    keep_w = 8'hF0;
            3'h6:    keep_w = 8'hC0;
            3'h7:    keep_w = 8'h80;
            default: keep_w = 8'hFF;
        endcase
    end

    // termination choice: leveling forces nominal, writes use dynamic
    wire logic use_wr_w  = write_burst && dwt_on_w
                         && !write_leveling; // [R2] [R3]
    wire logic use_nom_w = !use_wr_w && (nominal_term != `TERM_OFF);
    wire logic [2:0] wr_term_w = {1'b0, dwt_reg};

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            term_sel   <= TERM_NONE;
            term_value <= `TERM_OFF;
            read_data  <= 8'h00;
        end
        else
        begin
            term_sel   <= use_wr_w ? TERM_WRITE
                        : (use_nom_w ? TERM_NOMINAL : TERM_NONE);
            term_value <= use_wr_w ? wr_term_w : nominal_term; // [R3]
            if (read_burst)
                read_data <= rdo_reg ? `RDO_PATTERN
                                     : array_data; // [R15]
        end
    end

    assign partial_array_retention = ret_reg;
    assign write_column_latency    = wcl_w;
    assign wcl_reserved            = wcl_res_w;
    assign total_write_delay       = twd_w;
    assign dyn_term_code           = dwt_reg;
    assign dyn_term_reserved       = dwt_reg == 2'h3; // [R18]
    assign hot_self_refresh_option = hot_reg;
    assign self_refresh_2x         = hot_reg; // [R9]
    assign multipurpose_readout    = rdo_reg;
    assign readout_location        = rdo_reg ? loc_reg : 2'h0; // [R14]
    assign bank_keep_mask          = keep_w;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_LOAD_TWO_WCL: assert property // [R5]
        (@(posedge mclk) disable iff (!rst_b)
        load_two |=> write_column_latency
            == `WCL_BASE + $past(addr[`WCL_MSB:`WCL_LSB]))
        else $error("latency not taken from load");
    AST_TWD_SUM: assert property // [R7]
        (@(posedge mclk) disable iff (!rst_b)
        total_write_delay == additive_latency + write_column_latency)
        else $error("total write delay wrong");
    AST_LEVEL_NOMINAL: assert property // [R3]
        (@(posedge mclk) disable iff (!rst_b)
        write_leveling |=> term_sel != TERM_WRITE)
        else $error("dynamic termination during leveling");
    AST_WR_TERM: assert property // [R2]
        (@(posedge mclk) disable iff (!rst_b)
        (write_burst && !write_leveling && dwt_on_w)
        |=> term_sel == TERM_WRITE)
        else $error("write termination not applied");
    AST_THREE_KEEPS_TWO: assert property // [R19]
        (@(posedge mclk) disable iff (!rst_b)
        load_three |=> $stable(wcl_reg) && $stable(dwt_reg))
        else $error("third load changed second register");
    AST_HOT_2X: assert property // [R9]
        (@(posedge mclk) disable iff (!rst_b)
        (load_two && addr[`HOT_BIT]) |=> self_refresh_2x)
        else $error("hot option not set");
    AST_LOC_IGNORED: assert property // [R14]
        (@(posedge mclk) disable iff (!rst_b)
        !multipurpose_readout |-> readout_location == 2'h0)
        else $error("readout location used while off");
    AST_PATTERN: assert property // [R15]
        (@(posedge mclk) disable iff (!rst_b)
        (read_burst && rdo_reg) |=> read_data == `RDO_PATTERN)
        else $error("readout pattern missing");
    AST_DWT_LOAD: assert property // [R8]
        (@(posedge mclk) disable iff (!rst_b)
        load_two |=> dyn_term_code == $past(addr[`DWT_MSB:`DWT_LSB]))
        else $error("dynamic termination code not loaded");
    AST_WCL_RES: assert property // [R17]
        (@(posedge mclk) disable iff (!rst_b)
        (load_two && addr[`WCL_MSB:`WCL_MSB-1] == 2'h3) |=> wcl_reserved)
        else $error("reserved latency code not flagged");
    AST_KEEP_TWO: assert property // [R16]
        (@(posedge mclk) disable iff (!rst_b)
        !load_two |=> $stable(ret_reg) && $stable(wcl_reg)
            && $stable(hot_reg) && $stable(dwt_reg))
        else $error("second register changed without its load");
    AST_KEEP_THREE: assert property // [R12]
        (@(posedge mclk) disable iff (!rst_b)
        !load_three |=> $stable(rdo_reg) && $stable(loc_reg))
        else $error("third register changed without its load");

endmodule
`default_nettype wire

// [logic/mode_two_three_params.svh]
// constants for the second and third mode register decode block
// assumes inclusion by bare name from the design file
`ifndef MODE_TWO_THREE_PARAMS_SVH
`define MODE_TWO_THREE_PARAMS_SVH

`define BA_MODE_TWO      3'h2
`define BA_MODE_THREE    3'h3
`define RET_LSB          0
`define RET_MSB          2
`define WCL_LSB          3
`define WCL_MSB          5
`define HOT_BIT          7
`define DWT_LSB          9
`define DWT_MSB          10
`define RDO_LOC_LSB      0
`define RDO_LOC_MSB      1
`define RDO_EN_BIT       2
`define WCL_BASE         4'h5
`define WCL_MAX_CODE     3'h5
`define DWT_OFF          2'h0
`define DWT_RZQ4         2'h1
`define DWT_RZQ2         2'h2
`define RET_FULL         3'h0
`define WCL_RST          3'h0
`define RDO_PATTERN      8'h55
`define TERM_OFF         3'h0

`endif

// [logic/mode_two_three_pkg.sv]
// types for the second and third mode register decode block
// needs no params header; only the design file includes it
`default_nettype none
package mode_two_three_pkg;
    typedef enum logic [1:0]
    {
        TERM_NONE,
        TERM_NOMINAL,
        TERM_WRITE
    } term_sel_t;
endpackage
`default_nettype wire

// [verification/mrs_ctrl_model.sv]
// controller model issuing one-cycle mode register loads
// assumes a free-running mclk from the bench
`default_nettype none
module mrs_ctrl_model
(
    // clock
    input  wire logic        mclk,
    // command and address
    output var  logic        cs_b,
    output var  logic        ras_b,
    output var  logic        cas_b,
    output var  logic        we_b,
    output var  logic [2:0]  bank_addr,
    output var  logic [13:0] addr
);
    timeunit 1ns;
    timeprecision 1ps;
    // controller's view of case temperature and its refresh spacing
    logic case_hot;
    int   refresh_interval_ns;
    always_comb refresh_interval_ns = case_hot ? 3900 : 7800;
    initial
    begin
        case_hot = 1'b0;
        cs_b = 1'b1;
        {ras_b, cas_b, we_b} = 3'h7;
        bank_addr = 3'h0;
        addr = 14'h0000;
    end
    // cmd holds ras, cas, we levels; all low is a register load
    // idle bank and address pins show the inverse of the last value; ras, cas, we go high
    task automatic load(input logic [2:0]  ba,
                        input logic [13:0] a,
                        input logic [2:0]  cmd = 3'h0);
        logic [13:0] v;
        v = a;
        if (ba == 3'h2)
            v = a & 14'h06BF;
        if (ba == 3'h2 && case_hot)
            v[7] = 1'b1;
        if (ba == 3'h3)
            v = a & 14'h0007;
        @(negedge mclk);
        cs_b = 1'b0;
        {ras_b, cas_b, we_b} = cmd;
        bank_addr = ba;
        addr = v;
        @(negedge mclk);
        cs_b = 1'b1;
        {ras_b, cas_b, we_b} = 3'h7;
        bank_addr = ~bank_addr;
        addr = ~addr;
    endtask
endmodule
`default_nettype wire

// [verification/tb_ddr3_mode_reg_two_three_decode.sv]
// self-checking bench for the mode register decode block
// assumes the package and the controller model are compiled first
`default_nettype none
module tb_ddr3_mode_reg_two_three_decode;
    timeunit 1ns;
    timeprecision 1ps;
    import mode_two_three_pkg::*;
    logic        mclk, rst_b, lvl, wb, rb, hot, mp;
    logic [2:0]  ret, wc, nom, ba, cmd;
    logic [1:0]  dw, lc;
    logic [3:0]  add_lat;
    logic [7:0]  arr, rd, r;
    logic [13:0] a;
    wire         cs_b, ras_b, cas_b, we_b;
    wire  [2:0]  bank;
    wire  [13:0] adr;
    wire  [41:0] obs;
    int          err_count, total_checks, cyc;
    logic [41:0] q[$];
    event        look;
    logic [7:0]  km[8] = '{8'hFF, 8'h0F, 8'h03, 8'h01,
                           8'hFC, 8'hF0, 8'hC0, 8'h80};
    mrs_ctrl_model ctl (.mclk(mclk), .cs_b(cs_b), .ras_b(ras_b),
        .cas_b(cas_b), .we_b(we_b), .bank_addr(bank), .addr(adr));
    ddr3_mode_reg_two_three_decode dut (.mclk(mclk), .rst_b(rst_b),
        .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b),
        .bank_addr(bank), .addr(adr), .additive_latency(add_lat),
        .write_leveling(lvl), .write_burst(wb), .nominal_term(nom),
        .read_burst(rb), .array_data(arr),
        .partial_array_retention(obs[41:39]),
        .write_column_latency(obs[38:35]), .wcl_reserved(obs[34]),
        .total_write_delay(obs[33:29]), .dyn_term_code(obs[28:27]),
        .dyn_term_reserved(obs[26]), .hot_self_refresh_option(obs[25]),
        .self_refresh_2x(obs[24]), .multipurpose_readout(obs[23]),
        .readout_location(obs[22:21]), .bank_keep_mask(obs[20:13]),
        .term_sel(obs[12:11]), .term_value(obs[10:8]), .read_data(obs[7:0]));
    //----------------------------------------------------------------
    // expectations, checking and closing
    //----------------------------------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [41:0] expv();
        logic [4:0] t;
        // leveling blocks write termination; codes 1 and 2 enable it
        t = (wb && !lvl && (dw == 2'h1 || dw == 2'h2))
          ? {TERM_WRITE, 1'b0, dw}
          : (nom != 3'h0) ? {TERM_NOMINAL, nom} : {TERM_NONE, 3'h0};
        return {ret, 4'h5 + 4'(wc), wc > 3'h5,
                5'(add_lat) + 5'h5 + 5'(wc), dw,
                dw == 2'h3, hot, hot, mp, lc, km[ret], t, rd};
    endfunction
    task automatic chk(input logic [41:0] s, input logic [41:0] e);
        total_checks++;
        if (s !== e)
        begin
            err_count++;
            $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
        end
    endtask
    task automatic note();
        @(posedge mclk);
        #1;
        q.push_back(expv());
        ->look;
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(look) chk(obs, q.pop_front());
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            err_count++;
            stop_test();
        end
    end
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial
    begin
        {rst_b, lvl, wb, rb, hot, mp, ret, wc, dw, lc, add_lat, arr, rd} = '0;
        nom = 3'h1;
        r = 8'h0D;
        repeat (8) @(negedge mclk);
        rst_b = 1'b1;
        note();
        for (int i = 0; i < 8; i++)
        begin
            @(negedge mclk);
            r = lfsr(r);
            add_lat = r[3:0];
            nom = r[6:4] | 3'h1;
            a = {3'h7, r[1:0], 1'b1, r[2], 1'b1, 3'(i), ~3'(i)};
            {ret, wc, hot, dw} = {~3'(i), 3'(i), r[2], r[1:0]};
            ctl.load(3'h2, a);
            note();
        end
        for (int i = 0; i < 8; i++)
        begin
            r = lfsr(r);
            ctl.load(3'h3, {11'h7FF, 3'(i)});
            {mp, lc} = {i[2], i[2] ? i[1:0] : 2'h0};
            {rb, arr} = {1'b1, r};
            rd = mp ? 8'h55 : r;
            note();
            @(negedge mclk);
            rb = 1'b0;
        end
        // wrong banks, or one strobe high, must leave both registers alone
        for (int k = 0; k < 6; k++)
        begin
            r = lfsr(r);
            ba = (k < 2) ? 3'(k) : (k < 4) ? 3'(k + 4) : 3'(k - 2);
            cmd = (k < 4) ? 3'h0 : (k == 4) ? 3'h2 : 3'h4;
            ctl.load(ba, {r, r[5:0]}, cmd);
            note();
        end
        ctl.case_hot = 1'b1;
        ctl.load(3'h2, 14'h0200);
        {ret, wc, hot, dw} = {3'h0, 3'h0, 1'b1, 2'h1};
        nom = 3'h0;
        wb = 1'b1;
        note();
        chk(42'(ctl.refresh_interval_ns), 42'hF3C);
        @(negedge mclk);
        lvl = 1'b1;
        nom = 3'h3;
        note();
        // reset again mid-run: every field back to its reset value
        @(negedge mclk);
        {rst_b, lvl, wb} = '0;
        repeat (2) @(negedge mclk);
        rst_b = 1'b1;
        {ret, wc, hot, dw, mp, lc, rd} = '0;
        note();
        stop_test();
    end
endmodule
`default_nettype wire
